/* File: hdl/synth_cfg_regs.svh */
/*
 * Register indices, field positions, fixed bit patterns and reset values
 * of the synthesizer configuration bank.
 * Assumes: included by bare name; byte address is four times the index.
 */
`ifndef SYNTH_CFG_REGS_SVH
`define SYNTH_CFG_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define IDX_FBDIV_HI   6'h22
`define IDX_FBDIV_LO   6'h24
`define IDX_SEED_DLY   6'h25
`define IDX_DEN_HI     6'h26
`define IDX_DEN_LO     6'h27
`define IDX_SEED_HI    6'h28
`define IDX_SEED_LO    6'h29
`define IDX_NUM_HI     6'h2a
`define IDX_NUM_LO     6'h2b
`define IDX_MOD_OUTA   6'h2c
`define IDX_OUT_LVL    6'h2d
`define IDX_OUTB_ROUTE 6'h2e
`define IDX_PIN_CFG    6'h3a

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define F_FBDIV_HI     2:0
`define F_SEED_EN      15
`define F_DLY_SEL      13:8
`define F_OUTA_LVL     13:8
`define F_OUT_B_POWERDOWN      7
`define F_OUT_A_POWERDOWN      6
`define F_MOD_RST_LOW  5
`define F_ORDER        2:0
`define F_OUTA_SRC     12:11
`define F_BOOST        10:9
`define F_OUTB_LVL     5:0
`define F_OUTB_SRC     1:0
`define F_PIN_IGNORE   15
`define F_PIN_HYST     14
`define F_PIN_BIAS     13:12
`define F_PIN_FMT      11:9

// ----------------------------------------------------------------------
// fixed bits that read back as one
// ----------------------------------------------------------------------
`define FIX_SEED_DLY   16'h0004
`define FIX_OUT_LVL    16'hc0c0
`define FIX_OUTB_ROUTE 16'h07fc
`define FIX_PIN_CFG    16'h0001

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_FBDIV      19'h00064
`define RST_SEED_EN    1'h0
`define RST_DLY_SEL    6'h02
`define RST_DEN        32'hffffffff
`define RST_NUM        32'h00000000
`define RST_SEED       32'h00000000
`define RST_OUTA_LVL   6'h1f
`define RST_OUT_B_POWERDOWN    1'h1
`define RST_OUT_A_POWERDOWN    1'h0
`define RST_MOD_RST    1'h1
`define RST_ORDER      3'h0
`define RST_BOOST      2'h0
`define RST_OUTB_LVL   6'h1f
`define RST_PIN_IGNORE 1'h1
`define RST_PIN_HYST   1'h0
`define RST_PIN_BIAS   2'h0
`define RST_PIN_FMT    3'h0

`endif

/* File: hdl/synth_cfg_pkg.sv */
/*
 * Types of the synthesizer configuration bank: output routing codes and
 * the packed state of each module.
 * Assumes: compiled before every module that imports it.
 */
package synth_cfg_pkg;

  typedef enum logic [1:0] {
    SRC_CHDIV  = 2'h0,
    SRC_OSC    = 2'h1,
    SRC_REQGEN = 2'h2,
    SRC_HIZ    = 2'h3
  } src_t;

  typedef struct packed {
    logic [31:0] seed;
  } seed_state_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [15:0] prdata;
    logic [18:0] fbdiv;
    logic        seed_en;
    logic [5:0]  dly_sel;
    logic [31:0] den;
    logic [31:0] num;
    logic [5:0]  out_a_level;
    logic        out_b_pd;
    logic        out_a_pd;
    logic        mod_rst_low;
    logic [2:0]  order;
    src_t        out_a_src;
    logic [1:0]  boost;
    logic [5:0]  out_b_level;
    src_t        out_b_src;
    logic        pin_ignore;
    logic        pin_hyst;
    logic [1:0]  pin_bias;
    logic [2:0]  pin_fmt;
    logic        frac_run;
    logic        order_rsvd;
    logic        out_a_on;
    logic        out_b_on;
    logic        pins_used;
    logic        pin_cfg_bad;
  } cfg_state_t;

endpackage

/* File: hdl/seed_accumulator.sv */
/*
 * Accumulating seed of the modulator's first accumulator: each write adds
 * its halfword, only the modulator reset clears it.
 * Assumes: add strobes are one-cycle pulses on pclk, never both at once.
 */
`timescale 1ns/1ps

`include "synth_cfg_regs.svh"

module seed_accumulator
  import synth_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        clear,
  input  wire logic        add_hi,
  input  wire logic        add_lo,
  input  wire logic [15:0] add_data,
  // state
  output logic      [31:0] seed
);
  import synth_cfg_pkg::*;

  seed_state_t s_reg;
  seed_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.seed = 32'h00000000;
    end else if (add_hi) begin
      s_next.seed = s_reg.seed + {add_data, 16'h0000};
    end else if (add_lo) begin
      s_next.seed = s_reg.seed + {16'h0000, add_data};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.seed <= `RST_SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  assign seed = s_reg.seed;

endmodule

/* File: hdl/synth_cfg_bank.sv */
/*
 * Configuration register bank of a fractional-N synthesizer: feedback
 * divider, fraction, modulator controls, both RF outputs and the
 * external sync/request pin setup, reached over APB.
 * Assumes: APB master on pclk; phase_sync_enable comes from logic on
 * the same clock.
 */
// Notes on behaviour
// - 19-bit feedback divider, high bits index 34, low 36, reset 100.
// - seed enable bit 15 of index 37, reset 0, lets seed apply.
// - each seed write adds its value to the accumulated seed.
// - only the modulator reset clears the accumulated seed.
// - modulator reset low holds modulator, ignores fractions; high runs.
// - order 0 integer, 1 to 4 modulator order, 5 to 7 reserved.
// - output A level field, reset 31, larger code more power.
// - power-down bits turn outputs off; B resets off, A on.
// - output A source: divider, oscillator, reserved, high impedance.
// - output B source: divider, oscillator, request generator, high-Z.
// - boost code 0 maximum, code 3 none.
// - output B level in index 45 bits 5:0, reset 31.
// - pin-ignore bit, reset 1, disregards pins; 0 needs phase sync.
// - pin format codes 0 to 3 valid, 4 to 7 invalid.
// - pin hysteresis bit and bias codes; bias code 3 invalid.
`timescale 1ns/1ps

`include "synth_cfg_regs.svh"

module synth_cfg_bank (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // loop settings
  input  wire logic               phase_sync_enable,
  output logic      [18:0]        feedback_divider,
  output logic      [5:0]         detector_delay_select,
  output logic      [31:0]        frac_numerator,
  output logic      [31:0]        frac_denominator,
  // modulator
  output logic                    seed_apply_enable,
  output logic      [31:0]        accumulator_seed,
  output logic                    modulator_reset_low,
  output logic      [2:0]         modulator_order,
  output logic                    frac_mode_run,
  output logic                    order_reserved,
  // rf outputs
  output logic      [5:0]         out_a_level,
  output logic      [5:0]         out_b_level,
  output logic                    out_a_powerdown,
  output logic                    out_b_powerdown,
  output synth_cfg_pkg::src_t     out_a_source,
  output synth_cfg_pkg::src_t     out_b_source,
  output logic      [1:0]         output_boost_level,
  output logic                    rf_output_first_on,
  output logic                    rf_output_second_on,
  // external input pins
  output logic                    ext_pins_disregard,
  output logic                    ext_pin_hysteresis,
  output logic      [1:0]         ext_pin_bias,
  output logic      [2:0]         ext_pin_format,
  output logic                    ext_pins_used,
  output logic                    ext_pin_cfg_invalid
);
  import synth_cfg_pkg::*;

  cfg_state_t  s_reg;
  cfg_state_t  s_next;
  logic [5:0]  idx;
  logic        hit;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  logic [15:0] add_word;
  logic        wr_fire;
  logic        seed_add_hi;
  logic        seed_add_lo;
  logic [31:0] seed_val;

  // ----------------------------------------------------------------------
  // address decode and read mux
  // ----------------------------------------------------------------------
  assign idx = paddr[7:2];

  always_comb begin
    hit     = (paddr[1:0] == 2'h0);
    rd_word = 16'h0000;
    case (idx)
      `IDX_FBDIV_HI:   rd_word = {13'h0000, s_reg.fbdiv[18:16]};
      `IDX_FBDIV_LO:   rd_word = s_reg.fbdiv[15:0];
      `IDX_SEED_DLY:   rd_word = {s_reg.seed_en, 1'h0, s_reg.dly_sel,
                                  8'h00} | `FIX_SEED_DLY;
      `IDX_DEN_HI:     rd_word = s_reg.den[31:16];
      `IDX_DEN_LO:     rd_word = s_reg.den[15:0];
      `IDX_SEED_HI:    rd_word = seed_val[31:16];
      `IDX_SEED_LO:    rd_word = seed_val[15:0];
      `IDX_NUM_HI:     rd_word = s_reg.num[31:16];
      `IDX_NUM_LO:     rd_word = s_reg.num[15:0];
      `IDX_MOD_OUTA:   rd_word = {2'h0, s_reg.out_a_level, s_reg.out_b_pd,
                                  s_reg.out_a_pd, s_reg.mod_rst_low, 2'h0,
                                  s_reg.order};
      `IDX_OUT_LVL:    rd_word = {3'h0, s_reg.out_a_src, s_reg.boost, 3'h0,
                                  s_reg.out_b_level} | `FIX_OUT_LVL;
      `IDX_OUTB_ROUTE: rd_word = {14'h0000, s_reg.out_b_src}
                                 | `FIX_OUTB_ROUTE;
      `IDX_PIN_CFG:    rd_word = {s_reg.pin_ignore, s_reg.pin_hyst,
                                  s_reg.pin_bias, s_reg.pin_fmt, 9'h000}
                                 | `FIX_PIN_CFG;
      default:         hit = 1'h0;
    endcase
  end

  // unstrobed bytes keep their value; for the seed they add nothing
  assign wr_word  = {pstrb[1] ? pwdata[15:8] : rd_word[15:8],
                     pstrb[0] ? pwdata[7:0]  : rd_word[7:0]};
  assign add_word = {pstrb[1] ? pwdata[15:8] : 8'h00,
                     pstrb[0] ? pwdata[7:0]  : 8'h00};
  assign wr_fire  = psel && penable && s_reg.pready && pwrite && hit;
  assign seed_add_hi = wr_fire && (idx == `IDX_SEED_HI);
  assign seed_add_lo = wr_fire && (idx == `IDX_SEED_LO);

  // ----------------------------------------------------------------------
  // seed accumulator
  // ----------------------------------------------------------------------
  seed_accumulator u_seed (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (!s_reg.mod_rst_low),
    .add_hi   (seed_add_hi),
    .add_lo   (seed_add_lo),
    .add_data (add_word),
    .seed     (seed_val)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // answer one cycle after setup, so the access phase lasts one cycle
    s_next.pready  = psel && !penable;
    s_next.pslverr = psel && !penable && !hit;
    if (psel && !penable) begin
      s_next.prdata = hit ? rd_word : 16'h0000;
    end
    if (wr_fire) begin
      case (idx)
        `IDX_FBDIV_HI:   s_next.fbdiv[18:16] = wr_word[`F_FBDIV_HI];
        `IDX_FBDIV_LO:   s_next.fbdiv[15:0]  = wr_word;
        `IDX_SEED_DLY: begin
          s_next.seed_en = wr_word[`F_SEED_EN];
          s_next.dly_sel = wr_word[`F_DLY_SEL];
        end
        `IDX_DEN_HI:     s_next.den[31:16] = wr_word;
        `IDX_DEN_LO:     s_next.den[15:0]  = wr_word;
        `IDX_NUM_HI:     s_next.num[31:16] = wr_word;
        `IDX_NUM_LO:     s_next.num[15:0]  = wr_word;
        `IDX_MOD_OUTA: begin
          s_next.out_a_level = wr_word[`F_OUTA_LVL];
          s_next.out_b_pd    = wr_word[`F_OUT_B_POWERDOWN];
          s_next.out_a_pd    = wr_word[`F_OUT_A_POWERDOWN];
          s_next.mod_rst_low = wr_word[`F_MOD_RST_LOW];
          s_next.order       = wr_word[`F_ORDER];
        end
        `IDX_OUT_LVL: begin
          s_next.out_a_src   = src_t'(wr_word[`F_OUTA_SRC]);
          s_next.boost       = wr_word[`F_BOOST];
          s_next.out_b_level = wr_word[`F_OUTB_LVL];
        end
        `IDX_OUTB_ROUTE: s_next.out_b_src = src_t'(wr_word[`F_OUTB_SRC]);
        `IDX_PIN_CFG: begin
          s_next.pin_ignore = wr_word[`F_PIN_IGNORE];
          s_next.pin_hyst   = wr_word[`F_PIN_HYST];
          s_next.pin_bias   = wr_word[`F_PIN_BIAS];
          s_next.pin_fmt    = wr_word[`F_PIN_FMT];
        end
        default: s_next.fbdiv = s_reg.fbdiv;
      endcase
    end
    // derived status, one cycle behind the fields
    s_next.frac_run    = s_reg.mod_rst_low && (s_reg.order != 3'h0)
                         && (s_reg.order <= 3'h4);
    s_next.order_rsvd  = (s_reg.order > 3'h4);
    s_next.out_a_on    = !s_reg.out_a_pd && (s_reg.out_a_src == SRC_CHDIV
                         || s_reg.out_a_src == SRC_OSC);
    s_next.out_b_on    = !s_reg.out_b_pd && (s_reg.out_b_src != SRC_HIZ);
    s_next.pins_used   = !s_reg.pin_ignore && phase_sync_enable
                         && (s_reg.pin_fmt < 3'h4);
    s_next.pin_cfg_bad = (s_reg.pin_fmt >= 3'h4)
                         || (s_reg.pin_bias == 2'h3);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.pready      <= 1'h0;
      s_reg.pslverr     <= 1'h0;
      s_reg.prdata      <= 16'h0000;
      s_reg.fbdiv       <= `RST_FBDIV;
      s_reg.seed_en     <= `RST_SEED_EN;
      s_reg.dly_sel     <= `RST_DLY_SEL;
      s_reg.den         <= `RST_DEN;
      s_reg.num         <= `RST_NUM;
      s_reg.out_a_level <= `RST_OUTA_LVL;
      s_reg.out_b_pd    <= `RST_OUT_B_POWERDOWN;
      s_reg.out_a_pd    <= `RST_OUT_A_POWERDOWN;
      s_reg.mod_rst_low <= `RST_MOD_RST;
      s_reg.order       <= `RST_ORDER;
      s_reg.out_a_src   <= SRC_OSC;
      s_reg.boost       <= `RST_BOOST;
      s_reg.out_b_level <= `RST_OUTB_LVL;
      s_reg.out_b_src   <= SRC_OSC;
      s_reg.pin_ignore  <= `RST_PIN_IGNORE;
      s_reg.pin_hyst    <= `RST_PIN_HYST;
      s_reg.pin_bias    <= `RST_PIN_BIAS;
      s_reg.pin_fmt     <= `RST_PIN_FMT;
      s_reg.frac_run    <= 1'h0;
      s_reg.order_rsvd  <= 1'h0;
      s_reg.out_a_on    <= 1'h1;
      s_reg.out_b_on    <= 1'h0;
      s_reg.pins_used   <= 1'h0;
      s_reg.pin_cfg_bad <= 1'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata                = {16'h0000, s_reg.prdata};
  assign pready                = s_reg.pready;
  assign pslverr               = s_reg.pslverr;
  assign feedback_divider      = s_reg.fbdiv;
  assign detector_delay_select = s_reg.dly_sel;
  assign frac_numerator        = s_reg.num;
  assign frac_denominator      = s_reg.den;
  assign seed_apply_enable     = s_reg.seed_en;
  assign accumulator_seed      = seed_val;
  assign modulator_reset_low   = s_reg.mod_rst_low;
  assign modulator_order       = s_reg.order;
  assign frac_mode_run         = s_reg.frac_run;
  assign order_reserved        = s_reg.order_rsvd;
  assign out_a_level           = s_reg.out_a_level;
  assign out_b_level           = s_reg.out_b_level;
  assign out_a_powerdown       = s_reg.out_a_pd;
  assign out_b_powerdown       = s_reg.out_b_pd;
  assign out_a_source          = s_reg.out_a_src;
  assign out_b_source          = s_reg.out_b_src;
  assign output_boost_level    = s_reg.boost;
  assign rf_output_first_on    = s_reg.out_a_on;
  assign rf_output_second_on   = s_reg.out_b_on;
  assign ext_pins_disregard    = s_reg.pin_ignore;
  assign ext_pin_hysteresis    = s_reg.pin_hyst;
  assign ext_pin_bias          = s_reg.pin_bias;
  assign ext_pin_format        = s_reg.pin_fmt;
  assign ext_pins_used         = s_reg.pins_used;
  assign ext_pin_cfg_invalid   = s_reg.pin_cfg_bad;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        full_wr;
  logic [31:0] seed_lo_sum;
  assign full_wr     = wr_fire && (pstrb[1:0] == 2'h3);
  assign seed_lo_sum = seed_val + {16'h0000, pwdata[15:0]};

  property p_fbdiv_low;
    full_wr && idx == `IDX_FBDIV_LO
      |=> feedback_divider[15:0] == $past(pwdata[15:0]);
  endproperty
  a_fbdiv_low: assert property (p_fbdiv_low)
    else $error("feedback divider low half not written");

  property p_seed_en;
    full_wr && idx == `IDX_SEED_DLY |=> seed_apply_enable == $past(pwdata[15]);
  endproperty
  a_seed_en: assert property (p_seed_en)
    else $error("seed enable not written");

  property p_seed_add;
    full_wr && idx == `IDX_SEED_LO && modulator_reset_low
      |=> accumulator_seed == $past(seed_lo_sum);
  endproperty
  a_seed_add: assert property (p_seed_add)
    else $error("seed write did not accumulate");

  property p_seed_clear;
    !modulator_reset_low |=> accumulator_seed == 32'h00000000;
  endproperty
  a_seed_clear: assert property (p_seed_clear)
    else $error("seed not cleared under modulator reset");

  sequence s_hold_reset;
    full_wr && idx == `IDX_MOD_OUTA && !pwdata[5];
  endsequence
  property p_frac_off;
    s_hold_reset ##1 !(full_wr && idx == `IDX_MOD_OUTA) |-> ##1 !frac_mode_run;
  endproperty
  a_frac_off: assert property (p_frac_off)
    else $error("fractional mode ran under modulator reset");

  property p_order_rsvd;
    modulator_order > 3'h4 |=> order_reserved && !frac_mode_run;
  endproperty
  a_order_rsvd: assert property (p_order_rsvd)
    else $error("reserved order not flagged");

  property p_out_a_off;
    (out_a_powerdown || out_a_source == SRC_HIZ) |=> !rf_output_first_on;
  endproperty
  a_out_a_off: assert property (p_out_a_off)
    else $error("output A on while off or high impedance");

  property p_out_b_on;
    !out_b_powerdown && out_b_source == SRC_REQGEN |=> rf_output_second_on;
  endproperty
  a_out_b_on: assert property (p_out_b_on)
    else $error("output B not on with generator routed");

  property p_pins;
    ext_pins_disregard |=> !ext_pins_used;
  endproperty
  a_pins: assert property (p_pins)
    else $error("pins used while disregarded");

  property p_pin_bad;
    ext_pin_format >= 3'h4 || ext_pin_bias == 2'h3 |=> ext_pin_cfg_invalid;
  endproperty
  a_pin_bad: assert property (p_pin_bad)
    else $error("invalid pin setup not flagged");

  property p_apb_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not exactly one cycle after setup");

endmodule

/* File: bench/test_synth_cfg_bank.sv */
/*
 * Self-checking testbench of the synthesizer configuration bank: APB
 * tasks, lfsr stimulus, checks of fields, derived flags and readback.
 * Assumes: synth_cfg_pkg compiled first, header found by bare name.
 */
`timescale 1ns/1ps
`include "synth_cfg_regs.svh"

module test_synth_cfg_bank;
  import synth_cfg_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pse = 1'b0, err, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h4089, seed, num, den;
  logic [31:0] acc;
  logic [18:0] fbd, fbx;
  logic [3:0]  pstb = 4'hf;
  logic [15:0] v;
  logic [5:0]  dly, alv, blv;
  logic [2:0]  ord, pfm;
  logic [1:0]  bst, pbi;
  logic        sen, mrl, fmr, ordr, apd, bpd, aon, bon, pig, phy, pus, pinv;
  src_t        asrc, bsrc;
  int          n_fail = 0, compares = 0, cyc = 0, i;

  synth_cfg_bank dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_sync_enable(pse), .feedback_divider(fbd),
    .detector_delay_select(dly), .frac_numerator(num),
    .frac_denominator(den), .seed_apply_enable(sen),
    .accumulator_seed(seed), .modulator_reset_low(mrl),
    .modulator_order(ord), .frac_mode_run(fmr), .order_reserved(ordr),
    .out_a_level(alv), .out_b_level(blv), .out_a_powerdown(apd),
    .out_b_powerdown(bpd), .out_a_source(asrc), .out_b_source(bsrc),
    .output_boost_level(bst), .rf_output_first_on(aon),
    .rf_output_second_on(bon), .ext_pins_disregard(pig),
    .ext_pin_hysteresis(phy), .ext_pin_bias(pbi), .ext_pin_format(pfm),
    .ext_pins_used(pus), .ext_pin_cfg_invalid(pinv)
  );

  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {lf[31:16], d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // write, then let fields and derived flags land
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    apb(1'b1, {idx, 2'b00}, d);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [15:0] e);
    apb(1'b0, {idx, 2'b00}, 16'h0000);
    chk({err, rd}, {1'b0, 16'h0000, e});
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({13'h0, fbd}, 32'h64);
    chk({sen, dly}, {1'b0, 6'h02});
    chk(den, 32'hffffffff);
    chk({num, seed}, 64'h0);
    chk({mrl, ord, fmr, ordr}, 6'h20);
    chk({alv, blv, bpd, apd, asrc, bsrc, bst}, 20'h7df94);
    chk({aon, bon, pig, phy, pbi, pfm, pus}, 10'h280);
    rdc(`IDX_FBDIV_LO, 16'h0064);
    rdc(`IDX_SEED_DLY, 16'h0204);
    rdc(`IDX_MOD_OUTA, 16'h1fa0);
    rdc(`IDX_OUT_LVL, 16'hc8df);
    rdc(`IDX_OUTB_ROUTE, 16'h07fd);
    rdc(`IDX_PIN_CFG, 16'h8001);
    // divider, fraction and delay
    lf = nx(lf);
    wr(`IDX_FBDIV_HI, {13'h0, lf[18:16]});
    wr(`IDX_FBDIV_LO, lf[15:0]);
    chk({13'h0, fbd}, {13'h0, lf[18:0]});
    fbx = lf[18:0];
    wr(`IDX_NUM_HI, lf[31:16]);
    wr(`IDX_NUM_LO, lf[15:0]);
    wr(`IDX_DEN_HI, lf[15:0]);
    wr(`IDX_DEN_LO, 16'h0000);
    chk({num, den}, {lf, lf[15:0], 16'h0});
    // low byte lane only: upper byte of the halfword keeps its value
    @(posedge pclk);
    pstb <= 4'h1;
    wr(`IDX_NUM_LO, 16'h0000);
    @(posedge pclk);
    pstb <= 4'hf;
    chk(num, {lf[31:8], 8'h00});
    wr(`IDX_SEED_DLY, {1'b1, 1'b0, lf[5:0], 8'h04});
    chk({sen, dly}, {1'b1, lf[5:0]});
    // seed accumulates with carry; only modulator reset clears it
    wr(`IDX_SEED_LO, 16'hffff);
    wr(`IDX_SEED_LO, lf[15:0]);
    wr(`IDX_SEED_HI, lf[31:16]);
    acc = 32'hffff + {16'h0, lf[15:0]} + {lf[31:16], 16'h0};
    chk(seed, acc);
    rdc(`IDX_SEED_HI, acc[31:16]);
    wr(`IDX_SEED_DLY, 16'h0204);
    chk(seed, acc);
    wr(`IDX_MOD_OUTA, 16'h1f81);
    wr(`IDX_SEED_LO, 16'h1234);
    chk({seed, fmr}, 33'h0);
    // every modulator order with random level, power-down and reset bit
    for (i = 0; i < 8; i++) begin
      lf = nx(lf);
      v = {2'b00, lf[5:0], lf[8:6], 2'b00, i[2:0]};
      wr(`IDX_MOD_OUTA, v);
      chk({alv, bpd, apd, mrl, ord}, {20'h0, v[13:5], v[2:0]});
      chk({fmr, ordr}, {lf[6] && i > 0 && i < 5, i > 4});
    end
    // every source code of both outputs
    for (i = 0; i < 8; i++) begin
      lf = nx(lf);
      wr(`IDX_MOD_OUTA, {2'b00, 6'h1f, lf[1:0], 6'h21});
      v = {3'b110, i[1:0], lf[4:3], 3'b011, lf[10:5]};
      wr(`IDX_OUT_LVL, v);
      wr(`IDX_OUTB_ROUTE, {14'h01ff, ~i[1:0]});
      chk({asrc, bsrc}, {i[1:0], ~i[1:0]});
      chk({bst, blv}, {lf[4:3], lf[10:5]});
      chk(aon, !lf[0] && i[1:0] < 2);
      chk(bon, !lf[1] && i[1:0] != 0);
      rdc(`IDX_OUT_LVL, v);
    end
    // external pin setup with random sync enable
    for (i = 0; i < 16; i++) begin
      lf = nx(lf);
      @(posedge pclk);
      pse <= (i == 0) | lf[8];
      v = {lf[0] & (i != 0), lf[1], lf[3:2], lf[6:4] & {i != 0, 2'b11},
           9'h001};
      wr(`IDX_PIN_CFG, v);
      chk({pig, phy, pbi, pfm}, {25'h0, v[15:9]});
      chk(pus, !v[15] && pse && !v[11]);
      chk(pinv, v[11] || v[13:12] == 2'h3);
    end
    // unmapped and misaligned accesses are refused and change nothing
    apb(1'b1, 8'h8c, 16'h0007);
    chk({err, rd}, 33'h100000000);
    apb(1'b1, 8'h89, 16'h0007);
    chk({err, rd}, 33'h100000000);
    apb(1'b0, 8'h89, 16'h0000);
    chk({err, rd}, 33'h100000000);
    rdc(`IDX_FBDIV_HI, {13'h0, fbx[18:16]});
    conclude();
  end
endmodule
